// *** src/dma_defines.svh ***
// Offsets, field positions and reset values of the DMA controller.
// Assumes a 32-bit slave port, word-aligned registers.
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH

// Per-channel registers; channel 1 is one stride up
`define DMA_CH_STRIDE 8'h20
`define DMA_OFS_CTRL 8'h00
`define DMA_OFS_SRC 8'h04
`define DMA_OFS_DST 8'h08
`define DMA_OFS_CNT 8'h0C
`define DMA_OFS_STAT 8'h10

// Global registers
`define DMA_OFS_PRIO 8'h40
`define DMA_OFS_IRQ_STAT 8'h44
`define DMA_OFS_IRQ_CLR 8'h48
`define DMA_OFS_IRQ_EN 8'h4C

// Control register fields
`define DMA_CTRL_EN 0
`define DMA_CTRL_BURST 1
`define DMA_CTRL_EXT 2
`define DMA_CTRL_SIZE_LO 3
`define DMA_CTRL_SIZE_HI 4
`define DMA_CTRL_SINC 5
`define DMA_CTRL_DINC 6
`define DMA_CTRL_SWREQ 7

// Channel status register fields
`define DMA_STAT_BUSY 0
`define DMA_STAT_ERR 1
`define DMA_STAT_REM_LO 16

// Priority register field
`define DMA_PRIO_RR 0

// Interrupt bits: two per channel
`define DMA_IRQ_DONE 0
`define DMA_IRQ_ERR 1
`define DMA_IRQ_BITS 4

// Reset values
`define DMA_CTRL_RESET 8'h00
`define DMA_WORD_RESET 32'h0000_0000
`define DMA_CNT_RESET 16'h0000
`define DMA_IRQ_RESET 4'h0

// Size field codes
`define DMA_SIZE_BYTE 2'h0
`define DMA_SIZE_HALF 2'h1
`define DMA_SIZE_WORD 2'h2

`endif

// *** src/dma_pkg.sv ***
// Types of the DMA controller.
// Assumes numbers live in dma_defines.svh.
package dma_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_RD = 2'b10,
        ST_WR = 2'b11
    } eng_e;

    typedef struct packed {
        logic last;
    } arb_s;

    typedef struct packed {
        logic [3:0] status;
        logic [3:0] enable;
    } irq_s;

    typedef struct packed {
        logic [1:0][7:0] ctrl;
        logic [1:0][31:0] src;
        logic [1:0][31:0] dst;
        logic [1:0][31:0] cur_src;
        logic [1:0][31:0] cur_dst;
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] rem;
        logic [1:0] go;
        logic [1:0] err;
        logic [1:0] wait_neg;
        logic [1:0] clr;
        logic [1:0] tc;
        logic rr;
        eng_e st;
        logic ch;
        logic fresh;
        logic bus_req;
        logic [31:0] data;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [7:0] waddr;
    } dma_s;

endpackage

// *** src/dma_arbiter.sv ***
// Two-channel arbiter, fixed or round-robin.
// Assumes accept pulses when the engine takes the grant.
`timescale 1ns/1ns

module dma_arbiter (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Requests and mode
    input wire logic [1:0] req,
    input wire logic rr,
    input wire logic accept,
    // Grant
    output logic gnt_valid,
    output logic gnt_idx
);
    dma_pkg::arb_s s_r;
    dma_pkg::arb_s s_nxt;

    always_comb begin
        gnt_valid = |req;
        if (req == 2'b11) begin
            gnt_idx = rr ? ~s_r.last : 1'b0;
        end else begin
            gnt_idx = ~req[0];
        end
        s_nxt = s_r;
        if (accept) begin
            s_nxt.last = gnt_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// *** src/dma_irq.sv ***
// Sticky interrupt status, enable mask, write-one clear.
// Assumes one-cycle event pulses; a set beats a same-cycle clear.
`timescale 1ns/1ns
`include "dma_defines.svh"

module dma_irq (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Events and software access
    input wire logic [3:0] ev,
    input wire logic clr_we,
    input wire logic en_we,
    input wire logic [3:0] wdata,
    // State and interrupt lines
    output logic [3:0] status,
    output logic [3:0] enable,
    output logic irq_ch0,
    output logic irq_ch1
);
    dma_pkg::irq_s s_r;
    dma_pkg::irq_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (clr_we) begin
            s_nxt.status = s_nxt.status & ~wdata;
        end
        s_nxt.status = s_nxt.status | ev;
        if (en_we) begin
            s_nxt.enable = wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= {`DMA_IRQ_RESET, `DMA_IRQ_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign status = s_r.status;
    assign enable = s_r.enable;
    assign irq_ch0 = |(s_r.status[1:0] & s_r.enable[1:0]);
    assign irq_ch1 = |(s_r.status[3:2] & s_r.enable[3:2]);
endmodule

// *** src/direct_memory_access_controller.sv ***
// Two-channel DMA controller: register slave, arbiter, engine.
// Assumes a system bus that grants and answers with m_done/m_err.
//
// Operation
// - Two independent channels with own request pins, configuration and completion.
// - Any source and destination: memory or I/O, each address optionally fixed.
// - Fixed priority grants channel 0 before channel 1.
// - Round-robin drops the last granted channel to lowest priority.
// - Up to 65,536 transfers per block; count holds transfers minus one.
// - Transfer unit selectable as byte, half-word or word.
// - Cycle steal requests the bus per transfer and releases it between.
// - Burst holds the bus request until the whole block completes.
// - Software request bit starts the channel's block when external mode is off.
// - External mode starts transfers from the channel's own request pin.
// - Interrupt raised at block end and on transfer error.
// - Each channel has its own interrupt output.
// - Each channel interrupt maskable; status still recorded.
// - Cycle steal external: clear pulse each transfer, wait for request negation.
// - In burst the clear pulse comes only at the last transfer's start.
// - Last-transfer flag pulses when the block's final transfer starts.
`timescale 1ns/1ns
`include "dma_defines.svh"

module direct_memory_access_controller (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // System bus master
    output logic bus_req,
    input wire logic bus_gnt,
    output logic m_valid,
    output logic m_write,
    output logic [31:0] m_addr,
    output logic [1:0] m_size,
    output logic [31:0] m_wdata,
    input wire logic [31:0] m_rdata,
    input wire logic m_done,
    input wire logic m_err,
    // Device request pins
    input wire logic ch0_transfer_request_in,
    input wire logic ch1_transfer_request_in,
    output logic ch0_request_clear_out,
    output logic ch1_request_clear_out,
    output logic ch0_last_transfer_flag,
    output logic ch1_last_transfer_flag,
    // Interrupts
    output logic irq_ch0,
    output logic irq_ch1
);
    dma_pkg::dma_s s_r;
    dma_pkg::dma_s s_nxt;

    logic [1:0] drq;
    logic [1:0] chan_req;
    logic gnt_valid;
    logic gnt_idx;
    logic accept;
    logic [3:0] irq_ev;
    logic [3:0] irq_status;
    logic [3:0] irq_enable;
    logic irq_clr_we;
    logic irq_en_we;

    // Address step per unit
    function automatic logic [31:0] unit_step(input logic [1:0] size);
        unit_step = (size == `DMA_SIZE_WORD) ? 32'h0000_0004 :
                    (size == `DMA_SIZE_HALF) ? 32'h0000_0002 : 32'h0000_0001;
    endfunction

    // Channel of an offset
    function automatic logic chan_of(input logic [7:0] a);
        chan_of = a[5];
    endfunction

    // Offset within a channel window
    function automatic logic [7:0] ofs_of(input logic [7:0] a);
        ofs_of = {3'h0, a[4:0]};
    endfunction

    function automatic logic [31:0] read_reg(input dma_pkg::dma_s s, input logic [7:0] a,
                                             input logic [3:0] ist, input logic [3:0] ien);
        logic c;
        c = chan_of(a);
        read_reg = 32'h0000_0000;
        if (a < `DMA_OFS_PRIO) begin
            unique case (ofs_of(a))
                `DMA_OFS_CTRL: read_reg = {24'h00_0000, s.go[c], s.ctrl[c][6:0]};
                `DMA_OFS_SRC: read_reg = s.src[c];
                `DMA_OFS_DST: read_reg = s.dst[c];
                `DMA_OFS_CNT: read_reg = {16'h0000, s.cnt[c]};
                `DMA_OFS_STAT: read_reg = {s.rem[c], 14'h0000, s.err[c], s.go[c]};
                default: read_reg = 32'h0000_0000;
            endcase
        end else begin
            unique case (a)
                `DMA_OFS_PRIO: read_reg = {31'h0000_0000, s.rr};
                `DMA_OFS_IRQ_STAT: read_reg = {28'h000_0000, ist};
                `DMA_OFS_IRQ_EN: read_reg = {28'h000_0000, ien};
                default: read_reg = 32'h0000_0000;
            endcase
        end
    endfunction

    assign drq = {ch1_transfer_request_in, ch0_transfer_request_in};

    // Armed, started and error-free channels compete
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            chan_req[i] = s_r.ctrl[i][`DMA_CTRL_EN] & s_r.go[i] & ~s_r.err[i];
        end
    end

    assign accept = (s_r.st == dma_pkg::ST_IDLE) && gnt_valid;

    dma_arbiter u_arb (
        .hclk(hclk),
        .hresetn(hresetn),
        .req(chan_req),
        .rr(s_r.rr),
        .accept(accept),
        .gnt_valid(gnt_valid),
        .gnt_idx(gnt_idx)
    );

    always_comb begin
        logic c;
        logic [7:0] wa;
        logic [1:0] sz;
        c = s_r.ch;
        wa = s_r.waddr;
        sz = s_r.ctrl[c][`DMA_CTRL_SIZE_HI:`DMA_CTRL_SIZE_LO];
        s_nxt = s_r;
        irq_ev = 4'h0;
        s_nxt.clr = 2'b00;
        s_nxt.tc = 2'b00;

        // Register slave: write lands in its data phase
        s_nxt.wr_pend = hsel && htrans[1] && hready && hwrite;
        s_nxt.waddr = haddr[7:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            s_nxt.hrdata = read_reg(s_r, haddr[7:0], irq_status, irq_enable);
        end
        if (s_r.wr_pend && wa < `DMA_OFS_PRIO) begin
            unique case (ofs_of(wa))
                `DMA_OFS_CTRL: begin
                    s_nxt.ctrl[chan_of(wa)] = {1'b0, hwdata[6:0]};
                    if (hwdata[`DMA_CTRL_EN]) begin
                        s_nxt.rem[chan_of(wa)] = s_r.cnt[chan_of(wa)];
                        s_nxt.cur_src[chan_of(wa)] = s_r.src[chan_of(wa)];
                        s_nxt.cur_dst[chan_of(wa)] = s_r.dst[chan_of(wa)];
                        s_nxt.wait_neg[chan_of(wa)] = 1'b0;
                        if (!hwdata[`DMA_CTRL_EXT] && hwdata[`DMA_CTRL_SWREQ]) begin
                            s_nxt.go[chan_of(wa)] = 1'b1;
                        end
                    end else begin
                        s_nxt.go[chan_of(wa)] = 1'b0;
                    end
                end
                `DMA_OFS_SRC: s_nxt.src[chan_of(wa)] = hwdata;
                `DMA_OFS_DST: s_nxt.dst[chan_of(wa)] = hwdata;
                `DMA_OFS_CNT: s_nxt.cnt[chan_of(wa)] = hwdata[15:0];
                `DMA_OFS_STAT: begin
                    if (hwdata[`DMA_STAT_ERR]) begin
                        s_nxt.err[chan_of(wa)] = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (s_r.wr_pend && wa == `DMA_OFS_PRIO) begin
            s_nxt.rr = hwdata[`DMA_PRIO_RR];
        end

        // Pins restart a channel after negation
        for (int i = 0; i < 2; i++) begin
            if (!drq[i]) begin
                s_nxt.wait_neg[i] = 1'b0;
            end
            if (s_r.ctrl[i][`DMA_CTRL_EN] && s_r.ctrl[i][`DMA_CTRL_EXT] && !s_r.go[i] &&
                drq[i] && !s_r.wait_neg[i] && !s_r.err[i] &&
                !(s_r.st != dma_pkg::ST_IDLE && s_r.ch == 1'(i))) begin
                s_nxt.go[i] = 1'b1;
            end
        end

        // Transfer engine
        unique case (s_r.st)
            dma_pkg::ST_IDLE: begin
                s_nxt.bus_req = 1'b0;
                if (gnt_valid) begin
                    s_nxt.ch = gnt_idx;
                    s_nxt.bus_req = 1'b1;
                    s_nxt.st = dma_pkg::ST_REQ;
                end
            end
            dma_pkg::ST_REQ: begin
                if (bus_gnt) begin
                    s_nxt.st = dma_pkg::ST_RD;
                    s_nxt.fresh = 1'b1;
                end
            end
            dma_pkg::ST_RD: begin
                if (s_r.fresh) begin
                    s_nxt.fresh = 1'b0;
                    if (s_r.rem[c] == 16'h0000) begin
                        s_nxt.tc[c] = 1'b1;
                    end
                    if (s_r.ctrl[c][`DMA_CTRL_EXT]) begin
                        if (!s_r.ctrl[c][`DMA_CTRL_BURST]) begin
                            s_nxt.clr[c] = 1'b1;
                            s_nxt.wait_neg[c] = 1'b1;
                        end else if (s_r.rem[c] == 16'h0000) begin
                            s_nxt.clr[c] = 1'b1;
                        end
                    end
                end
                if (m_done) begin
                    if (m_err) begin
                        s_nxt.err[c] = 1'b1;
                        s_nxt.go[c] = 1'b0;
                        s_nxt.bus_req = 1'b0;
                        irq_ev[{c, 1'b1}] = 1'b1;
                        s_nxt.st = dma_pkg::ST_IDLE;
                    end else begin
                        s_nxt.data = m_rdata;
                        s_nxt.st = dma_pkg::ST_WR;
                    end
                end
            end
            dma_pkg::ST_WR: begin
                if (m_done) begin
                    if (m_err) begin
                        s_nxt.err[c] = 1'b1;
                        s_nxt.go[c] = 1'b0;
                        s_nxt.bus_req = 1'b0;
                        irq_ev[{c, 1'b1}] = 1'b1;
                        s_nxt.st = dma_pkg::ST_IDLE;
                    end else begin
                        if (s_r.ctrl[c][`DMA_CTRL_SINC]) begin
                            s_nxt.cur_src[c] = s_r.cur_src[c] + unit_step(sz);
                        end
                        if (s_r.ctrl[c][`DMA_CTRL_DINC]) begin
                            s_nxt.cur_dst[c] = s_r.cur_dst[c] + unit_step(sz);
                        end
                        if (s_r.rem[c] == 16'h0000) begin
                            s_nxt.go[c] = 1'b0;
                            s_nxt.ctrl[c][`DMA_CTRL_EN] = 1'b0;
                            irq_ev[{c, 1'b0}] = 1'b1;
                            s_nxt.bus_req = 1'b0;
                            s_nxt.st = dma_pkg::ST_IDLE;
                        end else begin
                            s_nxt.rem[c] = s_r.rem[c] - 16'h0001;
                            if (s_r.ctrl[c][`DMA_CTRL_BURST]) begin
                                s_nxt.st = dma_pkg::ST_RD;
                                s_nxt.fresh = 1'b1;
                            end else begin
                                s_nxt.bus_req = 1'b0;
                                s_nxt.st = dma_pkg::ST_IDLE;
                                if (s_r.ctrl[c][`DMA_CTRL_EXT]) begin
                                    s_nxt.go[c] = 1'b0;
                                end
                            end
                        end
                    end
                end
            end
        endcase
    end

    assign irq_clr_we = s_r.wr_pend && s_r.waddr == `DMA_OFS_IRQ_CLR;
    assign irq_en_we = s_r.wr_pend && s_r.waddr == `DMA_OFS_IRQ_EN;

    dma_irq u_irq (
        .hclk(hclk),
        .hresetn(hresetn),
        .ev(irq_ev),
        .clr_we(irq_clr_we),
        .en_we(irq_en_we),
        .wdata(hwdata[3:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq_ch0(irq_ch0),
        .irq_ch1(irq_ch1)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_r.hrdata;

    assign bus_req = s_r.bus_req;
    assign m_valid = (s_r.st == dma_pkg::ST_RD) || (s_r.st == dma_pkg::ST_WR);
    assign m_write = (s_r.st == dma_pkg::ST_WR);
    assign m_addr = m_write ? s_r.cur_dst[s_r.ch] : s_r.cur_src[s_r.ch];
    assign m_size = s_r.ctrl[s_r.ch][`DMA_CTRL_SIZE_HI:`DMA_CTRL_SIZE_LO];
    assign m_wdata = s_r.data;

    assign ch0_request_clear_out = s_r.clr[0];
    assign ch1_request_clear_out = s_r.clr[1];
    assign ch0_last_transfer_flag = s_r.tc[0];
    assign ch1_last_transfer_flag = s_r.tc[1];
endmodule

// *** bench/dma_bus_model.sv ***
// System bus memory model for the DMA master.
// Assumes one master; reads return address ^ KEY; ERR_ADDR reads fail.
`timescale 1ns/1ns

module dma_bus_model #(
    parameter logic [31:0] KEY = 32'hA5A5_0000,
    parameter logic [31:0] ERR_ADDR = 32'h0000_0E00
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // System bus
    input wire logic bus_req,
    output logic bus_gnt,
    input wire logic m_valid,
    input wire logic m_write,
    input wire logic [31:0] m_addr,
    input wire logic [31:0] m_wdata,
    output logic [31:0] m_rdata,
    output logic m_done,
    output logic m_err,
    // Observation
    output logic [15:0] wr_count,
    output logic [31:0] last_waddr,
    output logic [31:0] last_wdata
);
    logic [1:0] wcnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_gnt <= 1'b0;
            m_rdata <= 32'h0;
            m_done <= 1'b0;
            m_err <= 1'b0;
            wr_count <= 16'h0;
            last_waddr <= 32'h0;
            last_wdata <= 32'h0;
            wcnt <= 2'h0;
        end else begin
            bus_gnt <= bus_req;
            m_done <= 1'b0;
            m_err <= 1'b0;
            // Odd words wait two cycles
            if (m_valid && !m_done && wcnt == (m_addr[2] ? 2'h2 : 2'h0)) begin
                m_done <= 1'b1;
                m_err <= !m_write && m_addr == ERR_ADDR;
                m_rdata <= m_addr ^ KEY;
                wcnt <= 2'h0;
                if (m_write) begin
                    wr_count <= wr_count + 16'h1;
                    last_waddr <= m_addr;
                    last_wdata <= m_wdata;
                end
            end else begin
                // Scramble idle data
                m_rdata <= ~m_rdata;
                if (m_valid && !m_done) begin
                    wcnt <= wcnt + 2'h1;
                end
            end
        end
    end
endmodule

// *** bench/dma_props.sv ***
// Checks on the DMA system bus and request pins.
// Assumes binding to the top module.
`timescale 1ns/1ns

module dma_props (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // System bus
    input wire logic bus_req,
    input wire logic bus_gnt,
    input wire logic m_valid,
    input wire logic m_write,
    input wire logic [31:0] m_addr,
    input wire logic [1:0] m_size,
    input wire logic m_done,
    input wire logic m_err,
    // Request pins
    input wire logic ch0_request_clear_out,
    input wire logic ch1_request_clear_out,
    input wire logic ch0_last_transfer_flag
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_clear_single: assert property (ch0_request_clear_out |=> !ch0_request_clear_out)
        else $error("clear too long");
    a_clear_at_read: assert property (ch1_request_clear_out |-> $past(m_valid) && !$past(m_write))
        else $error("stray clear");
    a_last_at_read: assert property (ch0_last_transfer_flag |-> $past(m_valid) && !$past(m_write))
        else $error("stray last flag");
    a_access_owns_bus: assert property (m_valid |-> bus_req)
        else $error("no bus request");
    a_start_after_gnt: assert property ($rose(m_valid) |-> $past(bus_gnt))
        else $error("no grant");
    a_access_hold: assert property (m_valid && !m_done |=> m_valid && $stable(m_addr) && $stable(m_write))
        else $error("access changed");
    a_read_then_write: assert property (m_valid && !m_write && m_done && !m_err |=> m_valid && m_write)
        else $error("no write");
    a_error_stops: assert property (m_valid && m_done && m_err |=> !m_valid)
        else $error("ran past error");
    a_size_legal: assert property (m_valid |-> m_size != 2'h3)
        else $error("bad size");

    c_last: cover property (ch0_last_transfer_flag);
    c_error: cover property (m_done && m_err);
    c_clear: cover property (ch1_request_clear_out);
endmodule

bind direct_memory_access_controller dma_props i_dma_props (
    .hclk(hclk), .hresetn(hresetn), .bus_req(bus_req), .bus_gnt(bus_gnt),
    .m_valid(m_valid), .m_write(m_write), .m_addr(m_addr), .m_size(m_size),
    .m_done(m_done), .m_err(m_err), .ch0_request_clear_out(ch0_request_clear_out),
    .ch1_request_clear_out(ch1_request_clear_out),
    .ch0_last_transfer_flag(ch0_last_transfer_flag)
);

// *** bench/direct_memory_access_controller_tb.sv ***
// Bench: block transfer table, then pin, error and reset tests.
// Assumes dma_bus_model on the system bus; dma_props binds itself.
`timescale 1ns/1ns
`include "dma_defines.svh"

module direct_memory_access_controller_tb;
    localparam logic [31:0] KEY = 32'hA5A5_0000;
    localparam logic [31:0] ERR_ADDR = 32'h0000_0E00;
    typedef struct {logic ch; logic [7:0] ctrl; logic [15:0] cnt;} row_s;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, bus_req, bus_gnt;
    logic m_valid, m_write, m_done, m_err, irq_ch0, irq_ch1;
    logic [1:0] htrans, m_size, ext_req, ext_on, clr, tc;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, m_addr, m_wdata, m_rdata, last_waddr, last_wdata;
    logic [15:0] wr_count;
    logic rd_ch[$];
    int fail_count, num_checks, cycles, req_rise, tc_seen;
    row_s rows[4] = '{'{1'b0, 8'hF1, 16'h3}, '{1'b1, 8'hEB, 16'h2},
                      '{1'b0, 8'hC1, 16'h0}, '{1'b1, 8'hB3, 16'h1}};

    assign hready = hreadyout;

    direct_memory_access_controller i_direct_memory_access_controller (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_req(bus_req),
        .bus_gnt(bus_gnt), .m_valid(m_valid), .m_write(m_write), .m_addr(m_addr),
        .m_size(m_size), .m_wdata(m_wdata), .m_rdata(m_rdata), .m_done(m_done),
        .m_err(m_err), .ch0_transfer_request_in(ext_req[0]),
        .ch1_transfer_request_in(ext_req[1]), .ch0_request_clear_out(clr[0]),
        .ch1_request_clear_out(clr[1]), .ch0_last_transfer_flag(tc[0]),
        .ch1_last_transfer_flag(tc[1]), .irq_ch0(irq_ch0), .irq_ch1(irq_ch1)
    );

    dma_bus_model #(.KEY(KEY), .ERR_ADDR(ERR_ADDR)) i_dma_bus_model (
        .hclk(hclk), .hresetn(hresetn), .bus_req(bus_req), .bus_gnt(bus_gnt),
        .m_valid(m_valid), .m_write(m_write), .m_addr(m_addr), .m_wdata(m_wdata),
        .m_rdata(m_rdata), .m_done(m_done), .m_err(m_err), .wr_count(wr_count),
        .last_waddr(last_waddr), .last_wdata(last_wdata)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Requester and monitors
    always @(posedge hclk) begin
        ext_req <= ext_on & ~clr;
        cycles++;
        req_rise += int'($rose(bus_req));
        tc_seen += int'(tc[0]) + int'(tc[1]);
        if (m_valid && !m_write && m_done) rd_ch.push_back(m_addr[14]);
        if (cycles > 20000) begin
            fail_count++;
            $display("CHECK FAILED %0t timeout", $time);
            results();
        end
    end

    task automatic results;
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [31:0] ra(input logic ch, input logic [7:0] ofs);
        return {24'h0, ofs + (ch ? `DMA_CH_STRIDE : 8'h00)};
    endfunction

    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (!hready);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hready);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [31:0] a, exp, input string what);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        cmp(q, exp, what);
    endtask

    task automatic setup(input logic ch, input logic [15:0] cnt, input logic [31:0] src);
        wr(ra(ch, `DMA_OFS_CNT), {16'h0, cnt});
        wr(ra(ch, `DMA_OFS_SRC), src);
        wr(ra(ch, `DMA_OFS_DST), src + 32'h800);
    endtask

    initial begin
        row_s r;
        logic [31:0] src, step, q;
        int n0, t0, w0;
        {hresetn, hsel, htrans, haddr, hwrite, hwdata, ext_on} = '0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        wr(ra(0, `DMA_OFS_IRQ_EN), 32'hF);
        foreach (rows[i]) begin
            r = rows[i];
            src = r.ch ? 32'h5000 : 32'h1000;
            step = 32'h1 << r.ctrl[4:3];
            {n0, t0, w0} = {req_rise, tc_seen, int'(wr_count)};
            setup(r.ch, r.cnt, src);
            wr(ra(r.ch, `DMA_OFS_CTRL), {24'h0, r.ctrl});
            while (!(r.ch ? irq_ch1 : irq_ch0)) @(posedge hclk);
            cmp(32'(int'(wr_count) - w0), r.cnt + 32'h1, "count");
            cmp(last_waddr, src + 32'h800 + (r.ctrl[6] ? r.cnt * step : 0), "dst");
            cmp(last_wdata, (src + (r.ctrl[5] ? r.cnt * step : 0)) ^ KEY, "data");
            cmp(32'(req_rise - n0), r.ctrl[1] ? 32'h1 : r.cnt + 32'h1, "bus req");
            cmp(32'(tc_seen - t0), 32'h1, "last flag");
            cmp({30'h0, irq_ch1, irq_ch0}, r.ch ? 32'h2 : 32'h1, "irq lines");
            rdc(ra(0, `DMA_OFS_IRQ_STAT), r.ch ? 32'h4 : 32'h1, "irq status");
            wr(ra(0, `DMA_OFS_IRQ_CLR), 32'hF);
            rdc(ra(0, `DMA_OFS_IRQ_STAT), 32'h0, "irq cleared");
        end
        // Both pins, fixed then round-robin
        for (int m = 0; m < 2; m++) begin
            rd_ch.delete();
            wr(ra(0, `DMA_OFS_PRIO), 32'(m));
            for (int c = 0; c < 2; c++) begin
                setup(c[0], 16'h1, c[0] ? 32'h5000 : 32'h1000);
                wr(ra(c[0], `DMA_OFS_CTRL), 32'h75);
            end
            ext_on <= 2'b11;
            while (!(irq_ch0 && irq_ch1)) @(posedge hclk);
            ext_on <= 2'b00;
            cmp(32'(rd_ch.size()), 32'h4, "pin reads");
            if (m == 0) cmp({31'h0, rd_ch[0]}, 32'h0, "fixed order");
            else cmp({31'h0, rd_ch[0] ^ rd_ch[1]}, 32'h1, "rotation");
            wr(ra(0, `DMA_OFS_IRQ_CLR), 32'hF);
        end
        // Masked bus error
        wr(ra(0, `DMA_OFS_IRQ_EN), 32'h0);
        w0 = int'(wr_count);
        setup(1'b0, 16'h0, ERR_ADDR);
        wr(ra(0, `DMA_OFS_CTRL), 32'hF1);
        do ahb(1'b0, ra(0, `DMA_OFS_IRQ_STAT), 32'h0, q); while (!q[1]);
        cmp({31'h0, irq_ch0}, 32'h0, "masked irq");
        cmp(32'(int'(wr_count) - w0), 32'h0, "write after error");
        ahb(1'b0, ra(0, `DMA_OFS_STAT), 32'h0, q);
        cmp({31'h0, q[1]}, 32'h1, "error flag");
        wr(ra(0, `DMA_OFS_IRQ_EN), 32'hF);
        @(posedge hclk);
        cmp({31'h0, irq_ch0}, 32'h1, "error irq");
        n0 = req_rise;
        wr(ra(0, `DMA_OFS_CTRL), 32'hF1);
        repeat (10) @(posedge hclk);
        cmp(32'(req_rise - n0), 32'h0, "halted channel");
        wr(ra(0, `DMA_OFS_CTRL), 32'h0);
        wr(ra(0, `DMA_OFS_STAT), 32'h2);
        ahb(1'b0, ra(0, `DMA_OFS_STAT), 32'h0, q);
        cmp({31'h0, q[1]}, 32'h0, "error cleared");
        // Mid-run reset and unmapped offset
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        cmp({29'h0, bus_req, irq_ch0, irq_ch1}, 32'h0, "in reset");
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(ra(0, `DMA_OFS_IRQ_EN), 32'h0, "enable reset");
        rdc(ra(1, `DMA_OFS_CTRL), 32'h0, "ctrl reset");
        rdc(32'h7C, 32'h0, "unmapped");
        results();
    end
endmodule
